// ---- rtl/yuvc_config.sv ----
// Summary of operation
// - override field picks original or fixed chroma
// - fixed U used only for 01 or 11
// - fixed V used only for 10 or 11
// - range field sets input value interpretation
// - mode field selects coefficient standard
// - translate mode resets to 05h
// - reserved bits reset and read zero
// - fixed U and V reset to 00h
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none

module yuvc_config
    import yuvc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // chroma path
    input  wire yuvc_uv_t    uvIn,
    input  wire logic        uvInValid,
    output var  yuvc_uv_t    uvOut,
    output logic             uvOutValid,
    // converter configuration
    output var  yuvc_cfg_t   cfgOut
);
    import yuvc_pkg::*;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  mode_reg, mode_next;
    logic [7:0]  fixU_reg, fixU_next;
    logic [7:0]  fixV_reg, fixV_next;
    logic [31:0] rdat_reg, rdat_next;
    logic        err_reg,  err_next;
    logic [7:0]  cnvCnt_reg, cnvCnt_next;

    // bus phase strobes shared by decode, ready and the assertions
    logic        access;
    logic        wrEn;
    logic        hit;

    // decode used by both read and write paths
    function automatic logic addr_hit(input logic [11:0] a);
        return a == YUVC_ADDR_CTRL || a == YUVC_ADDR_MODE || a == YUVC_ADDR_FIXU
            || a == YUVC_ADDR_FIXV || a == YUVC_ADDR_STAT;
    endfunction

    assign access = psel && penable;
    assign hit    = addr_hit(paddr);
    assign wrEn   = access && pwrite && hit && pstrb[0] && clkEn;

    // next register values; slave answers with zero wait states
    always_comb begin
        ctrl_next   = ctrl_reg;
        mode_next   = mode_reg;
        fixU_next   = fixU_reg;
        fixV_next   = fixV_reg;
        rdat_next   = rdat_reg;
        err_next    = 1'b0;
        cnvCnt_next = cnvCnt_reg;
        if (wrEn) begin
            unique case (paddr)
                // reserved bits masked so they always read zero
                YUVC_ADDR_CTRL: ctrl_next = pwdata[7:0] & YUVC_MASK_CTRL;
                YUVC_ADDR_MODE: mode_next = pwdata[7:0] & YUVC_MASK_MODE;
                YUVC_ADDR_FIXU: fixU_next = pwdata[7:0];
                YUVC_ADDR_FIXV: fixV_next = pwdata[7:0];
                default:        ;
            endcase
        end
        // count converted samples as visible block state
        if (uvOutValid && clkEn) begin
            cnvCnt_next = cnvCnt_reg + 8'h01;
        end
        if (ctrl_reg[YUVC_BIT_CRST]) begin
            cnvCnt_next = 8'h00;
        end
        if (psel && !penable) begin
            rdat_next = 32'h0000_0000;
            unique case (paddr)
                YUVC_ADDR_CTRL: rdat_next[7:0] = ctrl_reg;
                YUVC_ADDR_MODE: rdat_next[7:0] = mode_reg;
                YUVC_ADDR_FIXU: rdat_next[7:0] = fixU_reg;
                YUVC_ADDR_FIXV: rdat_next[7:0] = fixV_reg;
                YUVC_ADDR_STAT: rdat_next[7:0] = cnvCnt_reg;
                default:        rdat_next = 32'h0000_0000;
            endcase
        end
        if (psel && !penable) begin
            err_next = !addr_hit(paddr);
        end
    end

    // registers, reset to documented defaults
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg   <= YUVC_RST_CTRL;
            mode_reg   <= YUVC_RST_MODE;
            fixU_reg   <= YUVC_RST_FIX;
            fixV_reg   <= YUVC_RST_FIX;
            rdat_reg   <= 32'h0000_0000;
            err_reg    <= 1'b0;
            cnvCnt_reg <= 8'h00;
        end else if (clkEn) begin
            ctrl_reg   <= ctrl_next;
            mode_reg   <= mode_next;
            fixU_reg   <= fixU_next;
            fixV_reg   <= fixV_next;
            rdat_reg   <= rdat_next;
            err_reg    <= err_next;
            cnvCnt_reg <= cnvCnt_next;
        end
    end

    // pready waits for clkEn so a frozen slave never completes
    assign pready  = access && clkEn;
    assign prdata  = rdat_reg;
    assign pslverr = access && err_reg;

    // ----------------------------------------------------------------
    // converter configuration
    // ----------------------------------------------------------------
    // reserved coefficient codes flagged so the converter can hold
    always_comb begin
        cfgOut.convReset = ctrl_reg[YUVC_BIT_CRST];
        cfgOut.uvSel     = ctrl_reg[YUVC_POS_UVSEL +: 2];
        cfgOut.range     = yuvc_range_t'(mode_reg[YUVC_POS_RANGE +: 2]);
        cfgOut.std       = yuvc_std_t'(mode_reg[YUVC_POS_XFER +: 3]);
        unique case (mode_reg[YUVC_POS_XFER +: 3])
            YUVC_STD_RSV0, YUVC_STD_RSV2, YUVC_STD_RSV3: cfgOut.stdValid = 1'b0;
            default:                                     cfgOut.stdValid = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // chroma substitution
    // ----------------------------------------------------------------
    logic muxValid;

    // converter in reset takes no samples
    assign muxValid = uvInValid && !ctrl_reg[YUVC_BIT_CRST];

    yuvc_uv_mux uMux (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .uvSel    (ctrl_reg[YUVC_POS_UVSEL +: 2]),
        .fixU     (fixU_reg),
        .fixV     (fixV_reg),
        .uvIn     (uvIn),
        .inValid  (muxValid),
        .uvOut    (uvOut),
        .outValid (uvOutValid)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // reset values, seen at the first edge after release; reserved bits read zero; writes without the low byte strobe are ignored
    a_mode_reset: assert property (@(posedge mclk)
        $fell(sys_rst) |-> mode_reg == YUVC_RST_MODE)
        else $error("translate mode not 05h after reset");
    a_fix_reset: assert property (@(posedge mclk)
        $fell(sys_rst) |-> fixU_reg == YUVC_RST_FIX && fixV_reg == YUVC_RST_FIX)
        else $error("fixed values not zero after reset");
    a_resv_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_reg & ~YUVC_MASK_CTRL) == 8'h00 && (mode_reg & ~YUVC_MASK_MODE) == 8'h00)
        else $error("reserved bit set");
    a_strb_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
        access && pwrite && !pstrb[0] && clkEn |=> $stable(fixU_reg) && $stable(fixV_reg))
        else $error("write without byte strobe changed a register");

    // chroma substitution, one cycle after the sample is taken
    a_fixu_used: assert property (@(posedge mclk) disable iff (sys_rst)
        clkEn && muxValid && ctrl_reg[4] && $stable(fixU_reg) |=> uvOutValid && uvOut.u == $past(fixU_reg))
        else $error("fixed U not applied");
    a_fixv_used: assert property (@(posedge mclk) disable iff (sys_rst)
        clkEn && muxValid && ctrl_reg[5] |=> uvOut.v == $past(fixV_reg))
        else $error("fixed V not applied");
    a_uv_pass: assert property (@(posedge mclk) disable iff (sys_rst)
        clkEn && muxValid && ctrl_reg[5:4] == 2'h0 |=> uvOut == $past(uvIn))
        else $error("chroma not passed through");

    // converter reset and configuration follow software writes
    a_crst_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        cfgOut.convReset && !(wrEn && paddr == YUVC_ADDR_CTRL) |=> cfgOut.convReset)
        else $error("converter reset released without write");
    a_uv_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        clkEn && uvInValid && cfgOut.convReset |=> !uvOutValid)
        else $error("sample accepted while converter held in reset");
    a_cnt_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        clkEn && cfgOut.convReset |=> cnvCnt_reg == 8'h00)
        else $error("sample count not cleared in converter reset");
    a_std_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wrEn && paddr == YUVC_ADDR_MODE |=> cfgOut.std == yuvc_std_t'($past(pwdata[2:0]))
            && cfgOut.range == yuvc_range_t'($past(pwdata[5:4])))
        else $error("configuration does not follow register write");

    // main scenarios the bench should reach
    c_write_ctrl: cover property (@(posedge mclk) wrEn && paddr == YUVC_ADDR_CTRL);
    c_fix_both:   cover property (@(posedge mclk) uvOutValid && ctrl_reg[5:4] == 2'h3);
    c_bad_addr:   cover property (@(posedge mclk) pready && pslverr);
    c_conv_rst:   cover property (@(posedge mclk) $rose(cfgOut.convReset));
    c_std_rsv:    cover property (@(posedge mclk) !cfgOut.stdValid);

endmodule

`default_nettype wire

// ---- rtl/yuvc_pkg.sv ----
package yuvc_pkg;

    // ----------------------------------------------------------------
    // register map (printed offsets are not all multiples of four,
    // so they are indices and the byte address is four times each)
    // ----------------------------------------------------------------
    localparam logic [7:0]  YUVC_IDX_CTRL  = 8'h2C;
    localparam logic [7:0]  YUVC_IDX_MODE  = 8'h2E;
    localparam logic [7:0]  YUVC_IDX_FIXU  = 8'h30;
    localparam logic [7:0]  YUVC_IDX_FIXV  = 8'h32;
    localparam logic [7:0]  YUVC_IDX_STAT  = 8'h40;

    localparam logic [11:0] YUVC_ADDR_CTRL = {2'h0, YUVC_IDX_CTRL, 2'h0};
    localparam logic [11:0] YUVC_ADDR_MODE = {2'h0, YUVC_IDX_MODE, 2'h0};
    localparam logic [11:0] YUVC_ADDR_FIXU = {2'h0, YUVC_IDX_FIXU, 2'h0};
    localparam logic [11:0] YUVC_ADDR_FIXV = {2'h0, YUVC_IDX_FIXV, 2'h0};
    localparam logic [11:0] YUVC_ADDR_STAT = {2'h0, YUVC_IDX_STAT, 2'h0};

    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0]  YUVC_RST_CTRL  = 8'h00;
    localparam logic [7:0]  YUVC_RST_MODE  = 8'h05;
    localparam logic [7:0]  YUVC_RST_FIX   = 8'h00;
    localparam logic [7:0]  YUVC_MASK_CTRL = 8'h70;  // bits 6..4 writable
    localparam logic [7:0]  YUVC_MASK_MODE = 8'h37;  // bits 5..4, 2..0
    localparam int          YUVC_BIT_CRST  = 6;
    localparam int          YUVC_POS_UVSEL = 4;
    localparam int          YUVC_POS_RANGE = 4;
    localparam int          YUVC_POS_XFER  = 0;

    // chroma override codes
    localparam logic [1:0]  YUVC_UV_PASS   = 2'h0;
    localparam logic [1:0]  YUVC_UV_FIXU   = 2'h1;
    localparam logic [1:0]  YUVC_UV_FIXV   = 2'h2;
    localparam logic [1:0]  YUVC_UV_FIXB   = 2'h3;

    // input range codes
    typedef enum logic [1:0] {
        YUVC_RNG_FULL_SIGNED   = 2'h0,
        YUVC_RNG_STUDIO_SIGNED = 2'h1,
        YUVC_RNG_FULL_UNSIGNED = 2'h2,
        YUVC_RNG_STUDIO_OFFSET = 2'h3
    } yuvc_range_t;

    // coefficient standard codes
    typedef enum logic [2:0] {
        YUVC_STD_RSV0   = 3'h0,
        YUVC_STD_BT709  = 3'h1,
        YUVC_STD_RSV2   = 3'h2,
        YUVC_STD_RSV3   = 3'h3,
        YUVC_STD_SYSM   = 3'h4,
        YUVC_STD_BT601  = 3'h5,
        YUVC_STD_S170M  = 3'h6,
        YUVC_STD_S240M  = 3'h7
    } yuvc_std_t;

    // converter configuration carried to the datapath
    typedef struct packed {
        logic        convReset;
        yuvc_range_t range;
        yuvc_std_t   std;
        logic        stdValid;
        logic [1:0]  uvSel;
    } yuvc_cfg_t;

    // one chroma sample pair
    typedef struct packed {
        logic [7:0] u;
        logic [7:0] v;
    } yuvc_uv_t;

endpackage

// ---- rtl/yuvc_uv_mux.sv ----
`timescale 1ns/1ns
`default_nettype none

module yuvc_uv_mux
    import yuvc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic [1:0] uvSel,
    input  wire logic [7:0] fixU,
    input  wire logic [7:0] fixV,
    input  wire yuvc_uv_t   uvIn,
    input  wire logic       inValid,
    output var  yuvc_uv_t   uvOut,
    output logic            outValid
);

    yuvc_uv_t uvReg;
    yuvc_uv_t uvNext;
    logic     vldReg;
    logic     vldNext;

    // pick original or fixed chroma per component
    always_comb begin
        uvNext  = uvReg;
        vldNext = inValid;
        if (inValid) begin
            uvNext.u = uvSel[0] ? fixU : uvIn.u;
            uvNext.v = uvSel[1] ? fixV : uvIn.v;
        end
    end

    // registered so downstream sees data from a flip-flop
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            uvReg  <= '0;
            vldReg <= 1'b0;
        end else if (clkEn) begin
            uvReg  <= uvNext;
            vldReg <= vldNext;
        end
    end

    assign uvOut    = uvReg;
    assign outValid = vldReg;

endmodule

`default_nettype wire

// ---- verification/test_yuv_converter_config.sv ----
`timescale 1ns/1ns
`default_nettype none

// one compare; every call is counted, a miss is printed at once
`define CHK(got, exp, msg) begin checkCount++; if ((got) !== (exp)) begin errTotal++; \
    $display("mismatch t=%0t %s", $time, msg); end end

module test_yuv_converter_config;
    import yuvc_pkg::*;

    logic        mclk;
    logic        sys_rst;
    logic        clkEn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    yuvc_uv_t    uvIn;
    logic        uvInValid;
    yuvc_uv_t    uvOut;
    logic        uvOutValid;
    yuvc_cfg_t   cfgOut;
    int          errTotal;
    int          checkCount;

    yuvc_config dut (
        .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .uvIn(uvIn), .uvInValid(uvInValid),
        .uvOut(uvOut), .uvOutValid(uvOutValid), .cfgOut(cfgOut)
    );

    // ----------------------------------------------------------------
    // clock, verdict and watchdog
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // the whole run needs about 140 cycles, so this is generous
    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        finishTest();
    end

    // ----------------------------------------------------------------
    // bus and sample drivers
    // ----------------------------------------------------------------
    // one apb transfer; starts at an edge so a release never meets a new request
    task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] strb, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) errTotal++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic regWr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b1, a, {24'h000000, d}, 4'hF, rd, err);
        // the write lands by non-blocking update at this edge; let it settle
        #1;
    endtask

    task automatic regChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apbXfer(1'b0, a, 32'h00000000, 4'h0, rd, err);
        `CHK(rd, exp, "register read value")
        `CHK(err, expErr, "slave error flag")
    endtask

    // one chroma sample; the result is looked at in the cycle it stands
    task automatic sendUv(input logic [7:0] u, input logic [7:0] v, input logic expValid,
                          input logic [7:0] eu, input logic [7:0] ev);
        @(posedge mclk);
        uvIn <= '{u: u, v: v};
        uvInValid <= 1'b1;
        @(posedge mclk);
        uvInValid <= 1'b0;
        #1;
        `CHK(uvOutValid, expValid, "chroma output valid")
        if (expValid) `CHK(uvOut, {eu, ev}, "chroma output value")
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testResetValues;
        regChk(YUVC_ADDR_CTRL, 32'h00000000, 1'b0);
        regChk(YUVC_ADDR_MODE, 32'h00000005, 1'b0);
        regChk(YUVC_ADDR_FIXU, 32'h00000000, 1'b0);
        regChk(YUVC_ADDR_FIXV, 32'h00000000, 1'b0);
        `CHK(cfgOut.std, YUVC_STD_BT601, "reset standard")
        `CHK(cfgOut.range, YUVC_RNG_FULL_SIGNED, "reset range")
    endtask

    // reserved bits must drop on write; unmapped places refuse
    task automatic testRegAccess;
        logic [31:0] rd;
        logic        err;
        regWr(YUVC_ADDR_FIXU, 8'hA5);
        regWr(YUVC_ADDR_FIXV, 8'h3C);
        regChk(YUVC_ADDR_FIXU, 32'h000000A5, 1'b0);
        regChk(YUVC_ADDR_FIXV, 32'h0000003C, 1'b0);
        // a write without the low byte strobe must leave the register alone
        apbXfer(1'b1, YUVC_ADDR_FIXU, 32'h000000FF, 4'h0, rd, err);
        regChk(YUVC_ADDR_FIXU, 32'h000000A5, 1'b0);
        apbXfer(1'b1, 12'h004, 32'h000000FF, 4'hF, rd, err);
        `CHK(err, 1'b1, "unmapped write not refused")
        regWr(YUVC_ADDR_MODE, 8'hFF);
        regChk(YUVC_ADDR_MODE, 32'h00000037, 1'b0);
        regWr(YUVC_ADDR_CTRL, 8'h8F);
        regChk(YUVC_ADDR_CTRL, 32'h00000000, 1'b0);
        regChk(12'h004, 32'h00000000, 1'b1);
    endtask

    task automatic testModes;
        logic [2:0] s;
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            regWr(YUVC_ADDR_MODE, {2'b00, s[1:0], 1'b0, s});
            `CHK(cfgOut.std, s, "coefficient standard")
            `CHK(cfgOut.stdValid, (s inside {1, 4, 5, 6, 7}), "standard valid")
            `CHK(cfgOut.range, s[1:0], "input range")
        end
    endtask

    // fixed values A5/3C were loaded before; input is 11/22
    task automatic testUvSel;
        logic [1:0] s;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            regWr(YUVC_ADDR_CTRL, {2'b00, s, 4'h0});
            `CHK(cfgOut.uvSel, s, "override field")
            sendUv(8'h11, 8'h22, 1'b1, s[0] ? 8'hA5 : 8'h11, s[1] ? 8'h3C : 8'h22);
        end
    endtask

    // converter reset stays until software clears it
    task automatic testConvReset;
        regChk(YUVC_ADDR_STAT, 32'h00000004, 1'b0);
        regWr(YUVC_ADDR_CTRL, 8'h40);
        regChk(YUVC_ADDR_CTRL, 32'h00000040, 1'b0);
        `CHK(cfgOut.convReset, 1'b1, "converter held")
        sendUv(8'h44, 8'h55, 1'b0, 8'h00, 8'h00);
        regChk(YUVC_ADDR_STAT, 32'h00000000, 1'b0);
        regWr(YUVC_ADDR_CTRL, 8'h00);
        regChk(YUVC_ADDR_CTRL, 32'h00000000, 1'b0);
        sendUv(8'h44, 8'h55, 1'b1, 8'h44, 8'h55);
        regChk(YUVC_ADDR_STAT, 32'h00000001, 1'b0);
    endtask

    // clock enable low freezes the chroma path and the sample count
    task automatic testClkEn;
        @(posedge mclk);
        clkEn <= 1'b0;
        uvIn <= '{u: 8'h66, v: 8'h77};
        uvInValid <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(uvOutValid, 1'b0, "output valid while frozen")
        `CHK(uvOut, 16'h4455, "output value while frozen")
        @(posedge mclk);
        clkEn <= 1'b1;
        uvInValid <= 1'b0;
        regChk(YUVC_ADDR_STAT, 32'h00000001, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        errTotal = 0;
        checkCount = 0;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        uvIn = '0;
        uvInValid = 1'b0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        testResetValues();
        testRegAccess();
        testModes();
        testUvSel();
        testConvReset();
        testClkEn();
        finishTest();
    end
endmodule

`default_nettype wire
